/* common/spm_defs.vh */
// Constants for the serial port mode configuration block
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH

// Clock and default line rate
`define SPM_CLK_HZ       40000000
`define SPM_BAUD_RATE    9600
`define SPM_BAUD_DIV     (`SPM_CLK_HZ / `SPM_BAUD_RATE)
`define SPM_BAUD_RST     16'h1045

// Register word indexes inside a port window (addr[4:2])
`define SPM_IDX_MODE     3'h0
`define SPM_IDX_BAUD     3'h1
`define SPM_IDX_TXD      3'h2
`define SPM_IDX_RXD      3'h3
`define SPM_IDX_CTRL     3'h4
`define SPM_IDX_STAT     3'h5
`define SPM_ADDR_INSTID  8'h40

// Feature bits of the combined feature value; the XONOFF and FIFO bits disable when set
`define SPM_F_QUIET      0
`define SPM_F_COMPUTER   1
`define SPM_F_SECURITY   2
`define SPM_F_HWHS       3
`define SPM_F_HESSEN     4
`define SPM_F_MDROP      5
`define SPM_F_MODEM      6
`define SPM_F_ERRCHK     7
`define SPM_F_XONOFF     8
`define SPM_F_FIFO       9
`define SPM_F_RS485      10
`define SPM_F_E71        11
`define SPM_F_PROMPT     12
`define SPM_F_E81        13
`define SPM_MODE_RST     16'h0380
`define SPM_MODE_MASK    16'h3FFF

// Control register bits and the transmit data unsolicited bit
`define SPM_C_TEST       0
`define SPM_C_LOGIN      1
`define SPM_C_LOGOUT     2
`define SPM_C_RELEASE    3
`define SPM_C_ERRCLR     4
`define SPM_TXD_UNSOL    8

// Characters
`define SPM_CH_W         8'h77
`define SPM_CH_HELP      8'h3F
`define SPM_CH_CR        8'h0D
`define SPM_CH_PROMPT    8'h3E
`define SPM_CH_XON       8'h11
`define SPM_CH_XOFF      8'h13
`define SPM_CH_A         8'h41
`define SPM_CH_T         8'h54

// Counts and sizes
`define SPM_TEST_LAST    9'h0FF
`define SPM_MDM_LAST     9'h002
`define SPM_BUF_DEPTH    3'h4
`define SPM_FLEN_PAR8    4'hB
`define SPM_FLEN_STD     4'hA
`define SPM_INSTID_RST   8'h01

// Bus responses
`define SPM_RESP_OKAY    2'h0
`define SPM_RESP_SLVERR  2'h2

`endif

/* core/spm_top.v */
// Two serial ports with per-port feature modes behind an AXI4-Lite slave
// Behaviour
// - Orientation switch swaps receive and transmit pins on first port only.
// - Each port's features are held and read back as one combined value.
// - Quiet mode holds unsolicited messages until software requests them.
// - Computer mode stops echo of received characters.
// - Regional protocol feature switches the port into that protocol.
// - Default frame 8N1; its feature selects even parity, 8 bits, 1 stop.
// - Its feature selects even parity, seven data bits, one stop bit.
// - Second port goes differential; that mode overrides multidrop.
// - With security on, only help character passes until login.
// - Multidrop shares a channel; each instrument answers its own ID.
// - Modem feature sends an init string and asserts modem lines.
// - Error fix feature accepts parity errors under the regional protocol.
// - Software flow control off by default; clearing the bit enables it.
// - Hardware handshake paces transmission by CTS and RTS.
// - Character buffer off by default; clearing the bit enables it.
// - Prompt feature outputs a prompt in terminal mode.
// - Each port keeps its own feature value.
// - Each port keeps its own baud; second port's also drives USB.
// - Test sends 256 'w' characters while the activity indicator toggles.
`include "spm_defs.vh"
`default_nettype none

module spm_top (
	// Clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// First port pins and orientation switch
	input  wire        dce_sel,
	input  wire        p0_pin2_i,
	output wire        p0_pin2_o,
	output wire        p0_pin2_oe,
	input  wire        p0_pin3_i,
	output wire        p0_pin3_o,
	output wire        p0_pin3_oe,
	// Second port pins
	input  wire        p1_rxd,
	output wire        p1_txd,
	output wire        rs485_de,
	// Handshake, modem and indicator lines, index is port
	input  wire [1:0]  cts_n,
	output wire [1:0]  rts_n,
	output wire [1:0]  dtr_n,
	output wire [1:0]  tx_led,
	// Mode status
	output wire [1:0]  hessen_on,
	output wire [1:0]  mdrop_on,
	output wire [15:0] usb_baud_div
);

	function [4:0] spm_dec;
		input [7:0] a;
		begin
			spm_dec = {(a[7:6] == 2'h0) && (a[1:0] == 2'h0) && (a[4:2] <= `SPM_IDX_STAT), a[5], a[4:2]};
		end
	endfunction

	function [31:0] spm_merge;
		input [31:0] o;
		input [31:0] n;
		input [3:0]  s;
		integer k;
		begin
			spm_merge = o;
			for (k = 0; k < 4; k = k + 1) begin
				if (s[k])
					spm_merge[k*8 +: 8] = n[k*8 +: 8];
			end
		end
	endfunction

	function [7:0] spm_mdm_char;
		input [1:0] i;
		begin
			case (i)
				2'h0: spm_mdm_char = `SPM_CH_A;
				2'h1: spm_mdm_char = `SPM_CH_T;
				default: spm_mdm_char = `SPM_CH_CR;
			endcase
		end
	endfunction

	// Write channel: address and data may arrive in either order
	reg        aw_h;
	reg        w_h;
	reg [7:0]  aw_a;
	reg [31:0] w_d;
	reg [3:0]  w_s;
	reg [7:0]  instid_reg;
	wire       wr_go = aw_h && w_h && !s_axi_bvalid;
	wire [4:0] wdec = spm_dec(aw_a);
	wire       wr_id = (aw_a == `SPM_ADDR_INSTID);

	assign s_axi_awready = !aw_h && !s_axi_bvalid;
	assign s_axi_wready  = !w_h && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_h         <= 1'b0;
			w_h          <= 1'b0;
			aw_a         <= 8'h00;
			w_d          <= 32'h0000_0000;
			w_s          <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SPM_RESP_OKAY;
			instid_reg   <= `SPM_INSTID_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h <= 1'b1;
				aw_a <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h <= 1'b1;
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_h         <= 1'b0;
				w_h          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wdec[4] || wr_id) ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
				if (wr_id && w_s[0])
					instid_reg <= w_d[7:0];
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Per-port views for the read side
	wire [31:0] mode_w;
	wire [31:0] baud_w;
	wire [17:0] rxd_w;
	wire [15:0] stat_w;
	wire [1:0]  txd_w;
	wire [1:0]  de_w;
	wire [1:0]  rx_in;
	wire [4:0]  rdec = spm_dec(s_axi_araddr);
	wire        rd_take = s_axi_arvalid && s_axi_arready;
	reg  [31:0] rd_mux;
	reg         rd_ok;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (s_axi_araddr == `SPM_ADDR_INSTID)
			rd_mux = {24'h00_0000, instid_reg};
		else if (rdec[4] && rdec[2:0] == `SPM_IDX_MODE)
			rd_mux = {16'h0000, mode_w[{rdec[3], 4'h0} +: 16]};
		else if (rdec[4] && rdec[2:0] == `SPM_IDX_BAUD)
			rd_mux = {16'h0000, baud_w[{rdec[3], 4'h0} +: 16]};
		else if (rdec[4] && rdec[2:0] == `SPM_IDX_RXD)
			rd_mux = {23'h00_0000, rxd_w[rdec[3] * 9 +: 9]};
		else if (rdec[4] && rdec[2:0] == `SPM_IDX_STAT)
			rd_mux = {24'h00_0000, stat_w[{rdec[3], 3'h0} +: 8]};
		else if (!rdec[4])
			rd_ok = 1'b0;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SPM_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// DTE receives on pin 2; the switch crosses the pair like a null modem
	assign rx_in[0]   = dce_sel ? p0_pin3_i : p0_pin2_i;
	assign rx_in[1]   = p1_rxd;
	assign p0_pin2_o  = txd_w[0];
	assign p0_pin3_o  = txd_w[0];
	assign p0_pin2_oe = dce_sel;
	assign p0_pin3_oe = !dce_sel;
	assign p1_txd     = txd_w[1];
	assign rs485_de   = de_w[1];
	assign usb_baud_div = baud_w[31:16];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : port
			localparam [0:0] PI = g;
			wire        wsel = wr_go && wdec[4] && (wdec[3] == PI);
			wire        rpop = rd_take && rdec[4] && (rdec[3] == PI) && (rdec[2:0] == `SPM_IDX_RXD);
			reg  [15:0] mode_reg;
			reg  [15:0] baud_reg;
			reg  [7:0]  bq [0:3];
			reg  [1:0]  wp;
			reg  [1:0]  rp;
			reg  [2:0]  cnt;
			reg  [10:0] sh;
			reg  [3:0]  nb;
			reg  [15:0] bc;
			reg         txd_r;
			reg         led_r;
			reg         de_r;
			reg         rts_r;
			reg         dtr_r;
			reg  [3:0]  rn;
			reg  [15:0] rc;
			reg  [10:0] rsh;
			reg  [7:0]  rxch_reg;
			reg         rxv_reg;
			reg         paused;
			reg         logged;
			reg         err_reg;
			reg         addr_reg;
			reg         echo_pend;
			reg  [7:0]  echo_ch;
			reg         prm_pend;
			reg         sw_pend;
			reg  [7:0]  sw_ch;
			reg         held_v;
			reg  [7:0]  held_ch;
			reg         gen_act;
			reg         gen_mdm;
			reg  [8:0]  gen_n;
			reg         mdm_pend;

			wire quiet  = mode_reg[`SPM_F_QUIET];
			wire comp   = mode_reg[`SPM_F_COMPUTER];
			wire secu   = mode_reg[`SPM_F_SECURITY];
			wire hwhs   = mode_reg[`SPM_F_HWHS];
			wire hess   = mode_reg[`SPM_F_HESSEN];
			wire modem  = mode_reg[`SPM_F_MODEM];
			wire rs485  = PI & mode_reg[`SPM_F_RS485];
			wire mdrop  = mode_reg[`SPM_F_MDROP] & ~rs485;
			wire xon_en = ~mode_reg[`SPM_F_XONOFF];
			wire fifo   = ~mode_reg[`SPM_F_FIFO];
			wire e81    = mode_reg[`SPM_F_E81];
			wire e71    = mode_reg[`SPM_F_E71] & ~e81;
			wire [3:0] flen = e81 ? `SPM_FLEN_PAR8 : `SPM_FLEN_STD;
			wire [7:0] hd = bq[rp];
			// Without the buffer only one character may wait
			wire full  = cnt >= (fifo ? `SPM_BUF_DEPTH : 3'h1);
			wire tbusy = (nb != 4'h0) || (bc != 16'h0000);
			wire tx_go = !tbusy && (cnt != 3'h0) && !paused && (!hwhs || !cts_n[g]);
			wire [10:0] tfr = e81 ? {1'b1, ^hd, hd, 1'b0} :
				e71 ? {2'h3, ^hd[6:0], hd[6:0], 1'b0} : {2'h3, hd, 1'b0};
			wire [10:0] nv = {rx_in[g], rsh[10:1]};
			wire rx_done = (rn == 4'h1) && (rc == 16'h0000);
			wire [7:0] rch = e81 ? nv[8:1] : e71 ? {1'b0, nv[8:2]} : nv[9:2];
			wire perr = e81 ? ^nv[9:1] : e71 ? ^nv[9:2] : 1'b0;
			wire rok = !perr || (hess && mode_reg[`SPM_F_ERRCHK]);
			wire flow = xon_en && (rch == `SPM_CH_XON || rch == `SPM_CH_XOFF);
			wire allow = !secu || logged || (rch == `SPM_CH_HELP);
			wire deliver = rx_done && rok && !flow && !(mdrop && !addr_reg) && allow;
			wire [8:0] gen_last = gen_mdm ? `SPM_MDM_LAST : `SPM_TEST_LAST;
			wire [7:0] gen_ch = gen_mdm ? spm_mdm_char(gen_n[1:0]) : `SPM_CH_W;
			wire src_v = gen_act || echo_pend || prm_pend || sw_pend;
			wire push = src_v && !full;
			wire [7:0] pch = gen_act ? gen_ch : echo_pend ? echo_ch : prm_pend ? `SPM_CH_PROMPT : sw_ch;
			wire [31:0] mode_mg = spm_merge({16'h0000, mode_reg}, w_d, w_s) & {16'h0000, `SPM_MODE_MASK};
			wire [31:0] baud_mg = spm_merge({16'h0000, baud_reg}, w_d, w_s);

			always @(posedge clk) begin
				if (push)
					bq[wp] <= pch;
			end

			// Registers, buffer pointers and transmitter
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					mode_reg <= `SPM_MODE_RST;
					baud_reg <= `SPM_BAUD_RST;
					wp       <= 2'h0;
					rp       <= 2'h0;
					cnt      <= 3'h0;
					sh       <= 11'h7FF;
					nb       <= 4'h0;
					bc       <= 16'h0000;
					txd_r    <= 1'b1;
					led_r    <= 1'b0;
					de_r     <= 1'b0;
					rts_r    <= 1'b1;
					dtr_r    <= 1'b1;
				end else begin
					if (wsel && wdec[2:0] == `SPM_IDX_MODE)
						mode_reg <= mode_mg[15:0];
					if (wsel && wdec[2:0] == `SPM_IDX_BAUD)
						baud_reg <= baud_mg[15:0];
					if (push)
						wp <= wp + 2'h1;
					if (tx_go)
						rp <= rp + 2'h1;
					if (push && !tx_go)
						cnt <= cnt + 3'h1;
					else if (!push && tx_go)
						cnt <= cnt - 3'h1;
					if (tx_go) begin
						txd_r <= 1'b0;
						sh    <= {1'b1, tfr[10:1]};
						nb    <= flen - 4'h1;
						bc    <= baud_reg;
						led_r <= ~led_r;
					end else if (tbusy) begin
						if (bc != 16'h0000) begin
							bc <= bc - 16'h0001;
						end else if (nb != 4'h0) begin
							txd_r <= sh[0];
							sh    <= {1'b1, sh[10:1]};
							nb    <= nb - 4'h1;
							bc    <= baud_reg;
						end
					end
					de_r  <= rs485 && (tx_go || tbusy);
					rts_r <= hwhs ? rxv_reg : !modem;
					dtr_r <= !modem;
				end
			end

			// Receiver and received character handling
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					rn        <= 4'h0;
					rc        <= 16'h0000;
					rsh       <= 11'h000;
					rxch_reg  <= 8'h00;
					rxv_reg   <= 1'b0;
					paused    <= 1'b0;
					err_reg   <= 1'b0;
					addr_reg  <= 1'b0;
					echo_pend <= 1'b0;
					echo_ch   <= 8'h00;
					prm_pend  <= 1'b0;
				end else begin
					if (rn == 4'h0) begin
						if (!rx_in[g]) begin
							rn <= flen;
							rc <= {1'b0, baud_reg[15:1]};
						end
					end else if (rc != 16'h0000) begin
						rc <= rc - 16'h0001;
					end else if (rn == flen && rx_in[g]) begin
						rn <= 4'h0;
					end else begin
						rsh <= nv;
						rn  <= rn - 4'h1;
						rc  <= baud_reg;
					end
					if (push && !gen_act && echo_pend)
						echo_pend <= 1'b0;
					if (push && !gen_act && !echo_pend && prm_pend)
						prm_pend <= 1'b0;
					if (rpop)
						rxv_reg <= 1'b0;
					if (wsel && wdec[2:0] == `SPM_IDX_CTRL && w_s[0] && w_d[`SPM_C_ERRCLR])
						err_reg <= 1'b0;
					if (!xon_en)
						paused <= 1'b0;
					if (rx_done && !rok)
						err_reg <= 1'b1;
					if (rx_done && rok && flow)
						paused <= (rch == `SPM_CH_XOFF);
					if (rx_done && rok && !flow && mdrop && !addr_reg && rch == instid_reg)
						addr_reg <= 1'b1;
					if (deliver) begin
						rxch_reg <= rch;
						rxv_reg  <= 1'b1;
						if (!comp) begin
							echo_pend <= 1'b1;
							echo_ch   <= rch;
						end
						if (rch == `SPM_CH_CR) begin
							addr_reg <= 1'b0;
							if (!comp && mode_reg[`SPM_F_PROMPT])
								prm_pend <= 1'b1;
						end
					end
				end
			end

			// Software sources, quiet hold, login and generators
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sw_pend  <= 1'b0;
					sw_ch    <= 8'h00;
					held_v   <= 1'b0;
					held_ch  <= 8'h00;
					logged   <= 1'b0;
					gen_act  <= 1'b0;
					gen_mdm  <= 1'b0;
					gen_n    <= 9'h000;
					mdm_pend <= 1'b1;
				end else begin
					if (push && !gen_act && !echo_pend && !prm_pend)
						sw_pend <= 1'b0;
					if (wsel && wdec[2:0] == `SPM_IDX_TXD && w_s[0]) begin
						if (quiet && w_d[`SPM_TXD_UNSOL]) begin
							held_v  <= 1'b1;
							held_ch <= w_d[7:0];
						end else begin
							sw_pend <= 1'b1;
							sw_ch   <= w_d[7:0];
						end
					end else if (wsel && wdec[2:0] == `SPM_IDX_CTRL && w_s[0]) begin
						if (w_d[`SPM_C_RELEASE] && held_v) begin
							held_v  <= 1'b0;
							sw_pend <= 1'b1;
							sw_ch   <= held_ch;
						end
						if (w_d[`SPM_C_LOGIN])
							logged <= 1'b1;
						else if (w_d[`SPM_C_LOGOUT])
							logged <= 1'b0;
						if (w_d[`SPM_C_TEST] && !gen_act) begin
							gen_act <= 1'b1;
							gen_mdm <= 1'b0;
							gen_n   <= 9'h000;
						end
					end else if (modem && mdm_pend && !gen_act) begin
						// First enable after power-up sends the init string once
						gen_act  <= 1'b1;
						gen_mdm  <= 1'b1;
						gen_n    <= 9'h000;
						mdm_pend <= 1'b0;
					end
					if (push && gen_act) begin
						gen_n <= gen_n + 9'h001;
						if (gen_n == gen_last)
							gen_act <= 1'b0;
					end
				end
			end

			assign mode_w[g*16 +: 16] = mode_reg;
			assign baud_w[g*16 +: 16] = baud_reg;
			assign rxd_w[g*9 +: 9]    = {rxv_reg, rxch_reg};
			assign stat_w[g*8 +: 8]   = {held_v, addr_reg, err_reg, paused, sw_pend,
				tbusy | (cnt != 3'h0), logged, gen_act & ~gen_mdm};
			assign txd_w[g]     = txd_r;
			assign de_w[g]      = de_r;
			assign tx_led[g]    = led_r;
			assign rts_n[g]     = rts_r;
			assign dtr_n[g]     = dtr_r;
			assign hessen_on[g] = hess;
			assign mdrop_on[g]  = mdrop;
		end
	endgenerate

endmodule // spm_top

`default_nettype wire

/* test/spm_monitor.sv */
// Assertion checker for the serial port mode block
`include "spm_defs.vh"
`default_nettype none
module spm_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Port pins and status
	input wire logic        dce_sel,
	input wire logic        p0_pin2_o,
	input wire logic        p0_pin2_oe,
	input wire logic        p0_pin3_o,
	input wire logic        p0_pin3_oe,
	input wire logic [1:0]  dtr_n,
	input wire logic [1:0]  hessen_on,
	input wire logic [1:0]  mdrop_on,
	input wire logic [15:0] usb_baud_div
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic wr_go;
	logic wr_full;
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign wr_full = wr_go && s_axi_wstrb == 4'hF;

	a_oe_follow_sel: assert property (p0_pin2_oe == dce_sel && p0_pin3_oe == !dce_sel)
		else $error("pin enables disagree with switch");
	a_pins_same_tx: assert property (p0_pin2_o == p0_pin3_o)
		else $error("pin outputs differ");
	a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_hessen_bit: assert property (wr_full && s_axi_awaddr == 8'h00 |-> ##2
		hessen_on[0] == $past(s_axi_wdata[`SPM_F_HESSEN], 2)) else $error("regional status wrong");
	a_mdrop_yield: assert property (wr_full && s_axi_awaddr == 8'h20 |-> ##2
		mdrop_on[1] == ($past(s_axi_wdata[5], 2) && !$past(s_axi_wdata[10], 2))) else $error("multidrop status wrong");
	a_usb_baud: assert property (wr_full && s_axi_awaddr == 8'h24 |-> ##2
		usb_baud_div == $past(s_axi_wdata[15:0], 2)) else $error("usb divider wrong");
	a_modem_line: assert property (wr_full && s_axi_awaddr == 8'h20 |-> ##3
		dtr_n[1] == !$past(s_axi_wdata[6], 3)) else $error("modem line wrong");
	a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7] |=>
		s_axi_rresp == `SPM_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule // spm_monitor
`default_nettype wire

/* test/spm_host_model.sv */
// Behavioural host terminal on the first serial port
`default_nettype none
module spm_host_model #(parameter int BIT_CLKS = 4) (
	// Clock
	input wire logic clk,
	// Serial lines
	input wire logic rx_line,
	output var logic tx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_ch;
	int         rx_cnt;
	int         w_cnt;
	initial begin
		tx_line = 1'b1;
		rx_cnt = 0;
		w_cnt = 0;
		last_ch = 8'h00;
	end
	// Mid-bit sampling, no parity expected
	always begin : rx_proc
		logic [7:0] sh;
		@(negedge rx_line);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			sh[i] = rx_line;
		end
		repeat (BIT_CLKS) @(posedge clk);
		last_ch = sh;
		rx_cnt++;
		if (sh == 8'h77)
			w_cnt++;
	end
	task automatic send(input logic [7:0] ch);
		logic [9:0] fr;
		fr = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			tx_line <= fr[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
	endtask
endmodule // spm_host_model
`default_nettype wire

/* test/tb_top.sv */
// Top testbench for the serial port mode block
`include "spm_defs.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset_n, dce_sel, h_tx, led_q;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, v0, v1;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, cts_n, rts_n, dtr_n, tx_led, hessen_on, mdrop_on;
	logic [15:0] usb_baud_div;
	logic        p0_pin2_o, p0_pin2_oe, p0_pin3_o, p0_pin3_oe, p1_txd, rs485_de;
	int          error_cnt, samples_checked, tog, c0, seed;
	wire logic   pin2 = p0_pin2_oe ? p0_pin2_o : h_tx;
	wire logic   pin3 = p0_pin3_oe ? p0_pin3_o : h_tx;
	wire logic   h_rx = dce_sel ? pin2 : pin3;

	spm_top i_spm_top (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dce_sel, .p0_pin2_i(pin2), .p0_pin2_o, .p0_pin2_oe, .p0_pin3_i(pin3), .p0_pin3_o,
		.p0_pin3_oe, .p1_rxd(1'b1), .p1_txd, .rs485_de, .cts_n, .rts_n, .dtr_n, .tx_led, .hessen_on,
		.mdrop_on, .usb_baud_div);
	spm_host_model #(.BIT_CLKS(4)) i_spm_host_model (.clk, .rx_line(h_rx), .tx_line(h_tx));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		led_q <= tx_led[0];
		if (reset_n && tx_led[0] !== led_q)
			tog++;
	end
	function automatic logic [31:0] mdrop_of(input logic [31:0] v);
		return {31'h0, v[5] & ~v[10]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ad, wd;
		n = 0;
		ad = 0;
		wd = 0;
		rs = 2'h3;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 300) begin
			@(posedge clk);
			n++;
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = 999;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		rs = 2'h3;
		v = 32'hFFFF_FFFF;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (n < 300) begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = 999;
			end else if (s_axi_rvalid === 1'b1) begin
				// Late ready makes the slave hold its answer a cycle
				s_axi_rready <= 1'b1;
			end
		end
	endtask
	task automatic wo(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, r);
		chk("bresp", 32'h0, {30'h0, r});
	endtask
	task automatic ro(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a, d, r);
		chk(nm, e, d);
	endtask
	task automatic give_verdict;
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		give_verdict;
	end

	initial begin
		seed = 32'hdc9d;
		error_cnt = 0;
		samples_checked = 0;
		tog = 0;
		reset_n = 1'b0;
		dce_sel = 1'b0;
		cts_n = 2'b00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		ro(8'h00, 32'h380, "mode0");
		ro(8'h20, 32'h380, "mode1");
		ro(8'h04, 32'h1045, "baud0");
		chk("usb", 32'h1045, {16'h0, usb_baud_div});
		for (int i = 0; i < 6; i++) begin
			// Modem bit kept off on port 0: its string would crawl at the reset rate
			v0 = (i == 0) ? 32'h3FBF : (i == 1) ? 32'h0 : $random(seed) & 32'hFFFF_FFBF;
			v1 = $random(seed);
			wo(8'h00, v0);
			wo(8'h20, v1);
			ro(8'h00, v0 & 32'h3FFF, "mode0");
			ro(8'h20, v1 & 32'h3FFF, "mode1");
			chk("hessen", {31'h0, v0[4]}, {31'h0, hessen_on[0]});
			chk("mdrop", mdrop_of(v1), {31'h0, mdrop_on[1]});
		end
		wr(8'h80, 32'h1, r);
		chk("bad wresp", 32'h2, {30'h0, r});
		rd(8'hC4, d, r);
		chk("bad rresp", 32'h2, {30'h0, r});
		wo(8'h24, 32'h3);
		chk("usb", 32'h3, {16'h0, usb_baud_div});
		ro(8'h04, 32'h1045, "baud0");
		wo(8'h04, 32'h3);
		for (int s = 0; s < 2; s++) begin
			dce_sel <= s[0];
			wo(8'h00, 32'h380);
			i_spm_host_model.send(8'h41 + 8'(s));
			repeat (120) @(posedge clk);
			chk("echo", 32'h41 + s, {24'h0, i_spm_host_model.last_ch});
			ro(8'h0C, 32'h141 + s, "rxd");
			chk("oe2", s, {31'h0, p0_pin2_oe});
		end
		wo(8'h00, 32'h382);
		c0 = i_spm_host_model.rx_cnt;
		i_spm_host_model.send(8'h54);
		repeat (120) @(posedge clk);
		chk("no echo", c0, i_spm_host_model.rx_cnt);
		ro(8'h0C, 32'h154, "rxd");
		wo(8'h00, 32'h383);
		wo(8'h08, 32'h155);
		repeat (100) @(posedge clk);
		chk("held", c0, i_spm_host_model.rx_cnt);
		rd(8'h14, d, r);
		chk("held flag", 32'h80, d & 32'h80);
		wo(8'h10, 32'h8);
		repeat (100) @(posedge clk);
		chk("released", 32'h55, {24'h0, i_spm_host_model.last_ch});
		wo(8'h00, 32'h38A);
		cts_n <= 2'b01;
		c0 = i_spm_host_model.rx_cnt;
		wo(8'h08, 32'h5A);
		repeat (100) @(posedge clk);
		chk("paced", c0, i_spm_host_model.rx_cnt);
		cts_n <= 2'b00;
		repeat (100) @(posedge clk);
		chk("cleared", 32'h5A, {24'h0, i_spm_host_model.last_ch});
		wo(8'h00, 32'h282);
		i_spm_host_model.send(8'h13);
		repeat (60) @(posedge clk);
		c0 = i_spm_host_model.rx_cnt;
		wo(8'h08, 32'h5A);
		repeat (100) @(posedge clk);
		chk("xoff", c0, i_spm_host_model.rx_cnt);
		i_spm_host_model.send(8'h11);
		repeat (100) @(posedge clk);
		chk("xon", c0 + 1, i_spm_host_model.rx_cnt);
		wo(8'h00, 32'h1380);
		c0 = i_spm_host_model.rx_cnt;
		i_spm_host_model.send(8'h0D);
		repeat (160) @(posedge clk);
		chk("prompt n", c0 + 2, i_spm_host_model.rx_cnt);
		chk("prompt", 32'h3E, {24'h0, i_spm_host_model.last_ch});
		wo(8'h00, 32'h386);
		i_spm_host_model.send(8'h54);
		repeat (60) @(posedge clk);
		ro(8'h0C, 32'h10D, "locked");
		i_spm_host_model.send(8'h3F);
		repeat (60) @(posedge clk);
		ro(8'h0C, 32'h13F, "help");
		wo(8'h00, 32'h382);
		c0 = i_spm_host_model.w_cnt;
		tog = 0;
		wo(8'h10, 32'h1);
		repeat (11000) @(posedge clk);
		chk("w count", 256, i_spm_host_model.w_cnt - c0);
		chk("led", 256, tog);
		c0 = i_spm_host_model.rx_cnt;
		wo(8'h00, 32'h3C2);
		repeat (300) @(posedge clk);
		chk("modem n", c0 + 3, i_spm_host_model.rx_cnt);
		chk("modem cr", 32'h0D, {24'h0, i_spm_host_model.last_ch});
		chk("dtr", 32'h0, {31'h0, dtr_n[0]});
		give_verdict;
	end
endmodule // tb_top

bind spm_top spm_monitor i_spm_monitor (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dce_sel, .p0_pin2_o,
	.p0_pin2_oe, .p0_pin3_o, .p0_pin3_oe, .dtr_n, .hessen_on, .mdrop_on, .usb_baud_div);
`default_nettype wire
